// >>> src/sbs_bank_tracker.sv
/*
  Bank state tracker for a four bank synchronous DRAM core: follows
  each bank and the device-wide states, and flags illegal commands.
  Assumes command pins are driven on the core clock by the controller.
*/
// How it works
// - Commands count only with clock enable steady high, except refresh as enable falls, which enters self refresh
// - Idle only after precharge period elapses
// - Row active once activate delay has elapsed
// - Read/write state lasts until burst ends
// - Precharging runs precharge period, then idle
// - Activating runs activate delay, then active
// - Read with auto precharge busy until idle
// - Write with auto precharge busy until idle
// - Refresh runs cycle time, then all idle
// - Mode load runs its delay, then idle
// - Precharge all runs precharge period
// - Burst terminate hits the latest burst
// - Precharge to idle bank does nothing
// - Strobe patterns decode into commands
// - Idle bank never blocks other banks
// - Busy bank allows other-bank commands
// - Select bit high requests auto precharge
// - Select bit high precharges all banks
`timescale 1ns/1ps
`include "sbs_regs.svh"
`default_nettype none

module sbs_bank_tracker #(
  parameter int unsigned PRE_CYC = `SBS_CYCLES_UP(`SBS_PRECHARGE_PERIOD_NS),
  parameter int unsigned ACT_CYC = `SBS_CYCLES_UP(`SBS_ACTIVATE_TO_COLUMN_DELAY_NS),
  parameter int unsigned REF_CYC = `SBS_CYCLES_UP(`SBS_REFRESH_CYCLE_NS),
  parameter int unsigned MODE_CYC = `SBS_CYCLES_UP(`SBS_MODE_LOAD_DELAY_NS),
  parameter int unsigned XSR_CYC = `SBS_CYCLES_UP(`SBS_SELF_REFRESH_EXIT_DELAY_NS),
  parameter int unsigned BURST_LEN = `SBS_BURST_LEN
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Command pins
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic i_auto_precharge_select,
  input wire logic [1:0] i_bank_select,
  // State view
  output var sbs_pkg::sbs_bank_e o_bank_state [4],
  output var sbs_pkg::sbs_dev_e o_dev_state,
  output var logic o_all_idle,
  output var logic o_cmd_illegal,
  output var logic [1:0] o_burst_bank,
  output var logic o_burst_live
);

  typedef logic [`SBS_CNT_W-1:0] sbs_cnt_t;

  localparam sbs_cnt_t PRE_N = `SBS_CNT_W'(PRE_CYC - 1);
  localparam sbs_cnt_t ACT_N = `SBS_CNT_W'(ACT_CYC - 1);
  localparam sbs_cnt_t REF_N = `SBS_CNT_W'(REF_CYC - 1);
  localparam sbs_cnt_t MODE_N = `SBS_CNT_W'(MODE_CYC - 1);
  localparam sbs_cnt_t XSR_N = `SBS_CNT_W'(XSR_CYC - 1);
  localparam sbs_cnt_t BL_N = `SBS_CNT_W'(BURST_LEN - 1);
  localparam sbs_cnt_t AP_N = `SBS_CNT_W'(BURST_LEN + PRE_CYC - 1);
  localparam int PRE_C = PRE_CYC;
  localparam int ACT_C = ACT_CYC;
  localparam int REF_C = REF_CYC;
  localparam int MODE_C = MODE_CYC;
  localparam int BL_C = BURST_LEN;
  localparam int AP_C = BURST_LEN + PRE_CYC;

  sbs_pkg::sbs_cmd_s cmd;
  sbs_pkg::sbs_bank_e bank_q [4];
  sbs_pkg::sbs_bank_e bank_d [4];
  sbs_cnt_t bcnt_q [4];
  sbs_cnt_t bcnt_d [4];
  sbs_pkg::sbs_dev_e dev_q, dev_d;
  sbs_cnt_t dcnt_q, dcnt_d;
  logic cke_q, cke_d;
  logic illegal_q, illegal_d;
  logic [1:0] last_q, last_d;
  logic live_q, live_d;
  logic all_idle_q, all_idle_d;
  logic run;

  sbs_cmd_decode u_decode (
    .i_cs_n(i_cs_n),
    .i_ras_n(i_ras_n),
    .i_cas_n(i_cas_n),
    .i_we_n(i_we_n),
    .i_auto_precharge_select(i_auto_precharge_select),
    .i_bank_select(i_bank_select),
    .o_cmd(cmd)
  );

  // Command taken only with enable high now and before, device running
  assign run = cke_q && i_cke && (dev_q == sbs_pkg::DV_RUN);

  // Per-bank state record
  for (genvar g = 0; g < 4; g++) begin : g_bank
    logic hit;
    assign hit = (cmd.bank == 2'(g));

    always_comb begin
      bank_d[g] = bank_q[g];
      bcnt_d[g] = (bcnt_q[g] == '0) ? '0 : bcnt_q[g] - `SBS_CNT_W'(1);
      unique case (bank_q[g])
        sbs_pkg::BK_IDLE, sbs_pkg::BK_ACTIVE: begin
        end
        sbs_pkg::BK_ACTIVATING: begin
          if (bcnt_q[g] == '0) begin
            bank_d[g] = sbs_pkg::BK_ACTIVE;
          end
        end
        sbs_pkg::BK_PRECHARGING: begin
          if (bcnt_q[g] == '0) begin
            bank_d[g] = sbs_pkg::BK_IDLE;
          end
        end
        sbs_pkg::BK_READ, sbs_pkg::BK_WRITE: begin
          if (bcnt_q[g] == '0) begin
            bank_d[g] = sbs_pkg::BK_ACTIVE;
          end
        end
        sbs_pkg::BK_READ_AP, sbs_pkg::BK_WRITE_AP: begin
          if (bcnt_q[g] == '0) begin
            bank_d[g] = sbs_pkg::BK_IDLE;
          end
        end
      endcase
      if (run) begin
        unique case (cmd.kind)
          sbs_pkg::CM_ACT: begin
            if (hit && bank_q[g] == sbs_pkg::BK_IDLE) begin
              bank_d[g] = sbs_pkg::BK_ACTIVATING;
              bcnt_d[g] = ACT_N;
            end
          end
          sbs_pkg::CM_READ, sbs_pkg::CM_WRITE: begin
            if (hit && (bank_q[g] == sbs_pkg::BK_ACTIVE || bank_q[g] == sbs_pkg::BK_READ ||
                        bank_q[g] == sbs_pkg::BK_WRITE)) begin
              if (cmd.ap) begin
                bank_d[g] = (cmd.kind == sbs_pkg::CM_READ) ? sbs_pkg::BK_READ_AP :
                            sbs_pkg::BK_WRITE_AP;
                bcnt_d[g] = AP_N;
              end else begin
                bank_d[g] = (cmd.kind == sbs_pkg::CM_READ) ? sbs_pkg::BK_READ :
                            sbs_pkg::BK_WRITE;
                bcnt_d[g] = BL_N;
              end
            end else if (!hit) begin
              // Other bank's burst cuts this one short
              if (bank_q[g] == sbs_pkg::BK_READ || bank_q[g] == sbs_pkg::BK_WRITE) begin
                bank_d[g] = sbs_pkg::BK_ACTIVE;
              end else if ((bank_q[g] == sbs_pkg::BK_READ_AP ||
                            bank_q[g] == sbs_pkg::BK_WRITE_AP) && bcnt_q[g] > PRE_N) begin
                bcnt_d[g] = PRE_N;
              end
            end
          end
          sbs_pkg::CM_TERM: begin
            if (live_q && last_q == 2'(g) &&
                (bank_q[g] == sbs_pkg::BK_READ || bank_q[g] == sbs_pkg::BK_WRITE)) begin
              bank_d[g] = sbs_pkg::BK_ACTIVE;
            end
          end
          sbs_pkg::CM_PRE: begin
            if ((cmd.ap || hit) && (bank_q[g] == sbs_pkg::BK_ACTIVE ||
                bank_q[g] == sbs_pkg::BK_READ || bank_q[g] == sbs_pkg::BK_WRITE)) begin
              bank_d[g] = sbs_pkg::BK_PRECHARGING;
              bcnt_d[g] = PRE_N;
            end
            // Idle bank keeps its state
          end
          default: begin
          end
        endcase
      end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        bank_q[g] <= sbs_pkg::BK_IDLE;
        bcnt_q[g] <= '0;
      end else begin
        bank_q[g] <= bank_d[g];
        bcnt_q[g] <= bcnt_d[g];
      end
    end

    assign o_bank_state[g] = bank_q[g];
  end

  // Device-wide state, legality and burst ownership
  always_comb begin
    logic idle_now;
    logic busy_tgt;
    logic pre_all_bad;
    sbs_pkg::sbs_bank_e tgt;
    tgt = bank_q[cmd.bank];
    busy_tgt = (tgt == sbs_pkg::BK_ACTIVATING || tgt == sbs_pkg::BK_PRECHARGING ||
                tgt == sbs_pkg::BK_READ_AP || tgt == sbs_pkg::BK_WRITE_AP);
    idle_now = 1'b1;
    pre_all_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (bank_q[i] != sbs_pkg::BK_IDLE) begin
        idle_now = 1'b0;
      end
      if (bank_q[i] == sbs_pkg::BK_ACTIVATING || bank_q[i] == sbs_pkg::BK_READ_AP ||
          bank_q[i] == sbs_pkg::BK_WRITE_AP) begin
        pre_all_bad = 1'b1;
      end
    end
    dev_d = dev_q;
    dcnt_d = (dcnt_q == '0) ? '0 : dcnt_q - `SBS_CNT_W'(1);
    cke_d = i_cke;
    illegal_d = 1'b0;
    last_d = last_q;
    live_d = 1'b0;
    unique case (dev_q)
      sbs_pkg::DV_RUN: begin
        if (run) begin
          if (cmd.kind == sbs_pkg::CM_REF) begin
            dev_d = sbs_pkg::DV_REFRESH;
            dcnt_d = REF_N;
          end else if (cmd.kind == sbs_pkg::CM_MODE) begin
            dev_d = sbs_pkg::DV_MODE;
            dcnt_d = MODE_N;
          end else if (cmd.kind == sbs_pkg::CM_PRE && cmd.ap) begin
            dev_d = sbs_pkg::DV_PRE_ALL;
            dcnt_d = PRE_N;
          end
        end else if (cke_q && !i_cke && cmd.kind == sbs_pkg::CM_REF && idle_now) begin
          dev_d = sbs_pkg::DV_SELF_REF;
        end
      end
      sbs_pkg::DV_REFRESH, sbs_pkg::DV_MODE, sbs_pkg::DV_PRE_ALL, sbs_pkg::DV_SR_EXIT: begin
        if (dcnt_q == '0) begin
          dev_d = sbs_pkg::DV_RUN;
        end
        if (dev_q != sbs_pkg::DV_SR_EXIT && cke_q &&
            cmd.kind != sbs_pkg::CM_INHIBIT && cmd.kind != sbs_pkg::CM_NOP) begin
          illegal_d = 1'b1;
        end
      end
      sbs_pkg::DV_SELF_REF: begin
        if (!cke_q && i_cke) begin
          dev_d = sbs_pkg::DV_SR_EXIT;
          dcnt_d = XSR_N;
        end
      end
    endcase
    if (dev_q == sbs_pkg::DV_SR_EXIT && cmd.kind != sbs_pkg::CM_INHIBIT &&
        cmd.kind != sbs_pkg::CM_NOP) begin
      illegal_d = 1'b1;
    end
    if (run) begin
      unique case (cmd.kind)
        sbs_pkg::CM_REF, sbs_pkg::CM_MODE: illegal_d = !idle_now;
        sbs_pkg::CM_ACT: illegal_d = (tgt != sbs_pkg::BK_IDLE);
        sbs_pkg::CM_READ, sbs_pkg::CM_WRITE: begin
          illegal_d = busy_tgt || tgt == sbs_pkg::BK_IDLE;
          last_d = cmd.bank;
        end
        sbs_pkg::CM_TERM: illegal_d = !live_q;
        sbs_pkg::CM_PRE: illegal_d = cmd.ap ? pre_all_bad : busy_tgt;
        default: illegal_d = 1'b0;
      endcase
    end
    // Burst stays live while its bank is in a plain read or write
    live_d = (bank_d[last_d] == sbs_pkg::BK_READ || bank_d[last_d] == sbs_pkg::BK_WRITE);
    all_idle_d = (dev_d == sbs_pkg::DV_RUN);
    for (int i = 0; i < 4; i++) begin
      if (bank_d[i] != sbs_pkg::BK_IDLE) begin
        all_idle_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dev_q <= sbs_pkg::DV_RUN;
      dcnt_q <= '0;
      cke_q <= 1'b0;
      illegal_q <= 1'b0;
      last_q <= 2'h0;
      live_q <= 1'b0;
      all_idle_q <= 1'b1;
    end else begin
      dev_q <= dev_d;
      dcnt_q <= dcnt_d;
      cke_q <= cke_d;
      illegal_q <= illegal_d;
      last_q <= last_d;
      live_q <= live_d;
      all_idle_q <= all_idle_d;
    end
  end

  assign o_dev_state = dev_q;
  assign o_all_idle = all_idle_q;
  assign o_cmd_illegal = illegal_q;
  assign o_burst_bank = last_q;
  assign o_burst_live = live_q;

  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_act_timing: assert property (
    run && cmd.kind == sbs_pkg::CM_ACT && cmd.bank == 2'h0 && bank_q[0] == sbs_pkg::BK_IDLE
    |=> bank_q[0] == sbs_pkg::BK_ACTIVATING ##ACT_C bank_q[0] == sbs_pkg::BK_ACTIVE)
    else $error("activate timing wrong");
  a_pre_timing: assert property (
    run && cmd.kind == sbs_pkg::CM_PRE && !cmd.ap && cmd.bank == 2'h0 &&
    bank_q[0] == sbs_pkg::BK_ACTIVE
    |=> bank_q[0] == sbs_pkg::BK_PRECHARGING ##PRE_C bank_q[0] == sbs_pkg::BK_IDLE)
    else $error("precharge timing wrong");
  a_pre_idle_noop: assert property (
    run && cmd.kind == sbs_pkg::CM_PRE && bank_q[1] == sbs_pkg::BK_IDLE
    |=> bank_q[1] == sbs_pkg::BK_IDLE)
    else $error("precharge changed idle bank");
  a_ref_span: assert property (
    run && cmd.kind == sbs_pkg::CM_REF && all_idle_q
    |=> o_dev_state == sbs_pkg::DV_REFRESH ##REF_C o_dev_state == sbs_pkg::DV_RUN && o_all_idle)
    else $error("refresh span wrong");
  a_mode_span: assert property (
    run && cmd.kind == sbs_pkg::CM_MODE && all_idle_q
    |=> o_dev_state == sbs_pkg::DV_MODE ##MODE_C o_dev_state == sbs_pkg::DV_RUN)
    else $error("mode load span wrong");
  a_cke_gate: assert property (
    (!i_cke || !cke_q) && bank_q[2] == sbs_pkg::BK_IDLE |=> bank_q[2] == sbs_pkg::BK_IDLE)
    else $error("command taken with clock enable low");
  a_rd_ap_busy: assert property (
    run && cmd.kind == sbs_pkg::CM_READ && cmd.ap && cmd.bank == 2'h0 &&
    bank_q[0] == sbs_pkg::BK_ACTIVE
    |=> bank_q[0] == sbs_pkg::BK_READ_AP ##[1:AP_C] bank_q[0] == sbs_pkg::BK_IDLE)
    else $error("read auto precharge span wrong");
  a_wr_ap_busy: assert property (
    run && cmd.kind == sbs_pkg::CM_WRITE && cmd.ap && cmd.bank == 2'h0 &&
    bank_q[0] == sbs_pkg::BK_ACTIVE
    |=> bank_q[0] == sbs_pkg::BK_WRITE_AP ##[1:AP_C] bank_q[0] == sbs_pkg::BK_IDLE)
    else $error("write auto precharge span wrong");
  a_burst_end: assert property (
    run && cmd.kind == sbs_pkg::CM_READ && !cmd.ap && cmd.bank == 2'h0 &&
    bank_q[0] == sbs_pkg::BK_ACTIVE
    |=> bank_q[0] == sbs_pkg::BK_READ ##[1:BL_C] bank_q[0] != sbs_pkg::BK_READ)
    else $error("read burst did not end");
  a_term_last: assert property (
    run && cmd.kind == sbs_pkg::CM_TERM && live_q
    |=> !o_burst_live && o_bank_state[$past(last_q)] == sbs_pkg::BK_ACTIVE)
    else $error("burst terminate missed latest burst");
  a_quiet_flag: assert property (
    dev_q == sbs_pkg::DV_REFRESH && cke_q && cmd.kind == sbs_pkg::CM_ACT |=> o_cmd_illegal)
    else $error("command during refresh not flagged");

endmodule

`default_nettype wire

// >>> src/sbs_regs.svh
/*
  Timing constants for the bank state tracker.
  Assumes a 40 MHz core clock; every count rounds a least time up.
*/
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

// Core clock period in ps
`define SBS_CLK_PERIOD_PS 25000
// Times in ns
`define SBS_PRECHARGE_PERIOD_NS 20
`define SBS_ACTIVATE_TO_COLUMN_DELAY_NS 20
`define SBS_REFRESH_CYCLE_NS 70
`define SBS_MODE_LOAD_DELAY_NS 15
`define SBS_SELF_REFRESH_EXIT_DELAY_NS 70
// Burst length in clocks
`define SBS_BURST_LEN 4
// Counter width
`define SBS_CNT_W 8
// Least time in ns to whole cycles
`define SBS_CYCLES_UP(ns) ((((ns) * 1000) + `SBS_CLK_PERIOD_PS - 1) / `SBS_CLK_PERIOD_PS)

`endif

// >>> src/sbs_pkg.sv
/*
  Types shared by the bank state tracker and its command decoder.
  Assumes nothing beyond a SystemVerilog tool.
*/
package sbs_pkg;

  typedef enum logic [2:0] {
    BK_IDLE,
    BK_ACTIVATING,
    BK_ACTIVE,
    BK_READ,
    BK_WRITE,
    BK_READ_AP,
    BK_WRITE_AP,
    BK_PRECHARGING
  } sbs_bank_e;

  typedef enum logic [2:0] {
    DV_RUN,
    DV_REFRESH,
    DV_MODE,
    DV_PRE_ALL,
    DV_SELF_REF,
    DV_SR_EXIT
  } sbs_dev_e;

  typedef enum logic [3:0] {
    CM_INHIBIT,
    CM_NOP,
    CM_ACT,
    CM_READ,
    CM_WRITE,
    CM_TERM,
    CM_PRE,
    CM_REF,
    CM_MODE
  } sbs_cmd_e;

  typedef struct packed {
    sbs_cmd_e kind;
    logic ap;
    logic [1:0] bank;
  } sbs_cmd_s;

endpackage

// >>> src/sbs_cmd_decode.sv
/*
  Command decoder: turns the four strobes, the auto precharge select
  and the bank select into one command word.
  Assumes the strobes are on the core clock; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module sbs_cmd_decode (
  // Command strobes
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  // Address bits
  input wire logic i_auto_precharge_select,
  input wire logic [1:0] i_bank_select,
  // Decoded command
  output sbs_pkg::sbs_cmd_s o_cmd
);

  always_comb begin
    o_cmd.ap = i_auto_precharge_select;
    o_cmd.bank = i_bank_select;
    if (i_cs_n) begin
      o_cmd.kind = sbs_pkg::CM_INHIBIT;
    end else begin
      unique case ({i_ras_n, i_cas_n, i_we_n})
        3'h7: o_cmd.kind = sbs_pkg::CM_NOP;
        3'h3: o_cmd.kind = sbs_pkg::CM_ACT;
        3'h5: o_cmd.kind = sbs_pkg::CM_READ;
        3'h4: o_cmd.kind = sbs_pkg::CM_WRITE;
        3'h6: o_cmd.kind = sbs_pkg::CM_TERM;
        3'h2: o_cmd.kind = sbs_pkg::CM_PRE;
        3'h1: o_cmd.kind = sbs_pkg::CM_REF;
        3'h0: o_cmd.kind = sbs_pkg::CM_MODE;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> test/sbs_ctl_model.sv
/*
  Command-side partner: a behavioural memory controller that drives the
  tracker's command pins on the falling edge of the core clock.
  Assumes the bench calls its tasks in turn, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module sbs_ctl_model (
  // Clock
  input wire logic i_core_clk,
  // Command pins toward the tracker
  output var logic o_cke,
  output var logic o_cs_n,
  output var logic o_ras_n,
  output var logic o_cas_n,
  output var logic o_we_n,
  output var logic o_ap,
  output var logic [1:0] o_bank
);
  initial begin
    o_cke = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_ap = 1'b0;
    o_bank = 2'h0;
  end

  // Strobe pattern per command
  task automatic drive(input sbs_pkg::sbs_cmd_e k);
    logic [3:0] s;
    case (k)
      sbs_pkg::CM_INHIBIT: s = 4'hf;
      sbs_pkg::CM_NOP: s = 4'h7;
      sbs_pkg::CM_ACT: s = 4'h3;
      sbs_pkg::CM_READ: s = 4'h5;
      sbs_pkg::CM_WRITE: s = 4'h4;
      sbs_pkg::CM_TERM: s = 4'h6;
      sbs_pkg::CM_PRE: s = 4'h2;
      sbs_pkg::CM_REF: s = 4'h1;
      default: s = 4'h0;
    endcase
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = s;
  endtask

  // One command for one cycle, then no-operation; callers may issue illegal commands on purpose
  task automatic issue(input sbs_pkg::sbs_cmd_e k, input logic ap, input logic [1:0] b,
                       input logic cke_now);
    @(negedge i_core_clk);
    o_cke = cke_now;
    drive(k);
    o_ap = ap;
    o_bank = b;
    @(negedge i_core_clk);
    drive(sbs_pkg::CM_NOP);
    o_ap = ~o_ap;
    o_bank = ~o_bank;
  endtask
endmodule

`default_nettype wire

// >>> test/tb.sv
/*
  Self-checking bench for the bank state tracker.
  Assumes the partner model drives all command pins.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int PRE = 2;
  localparam int ACT = 3;
  localparam int REF = 4;
  localparam int MODE = 2;
  localparam int XSR = 3;
  localparam int BL = 4;
  logic clk;
  logic rst_n;
  logic cke, cs_n, ras_n, cas_n, we_n, ap;
  logic [1:0] bsel;
  sbs_pkg::sbs_bank_e bs [4];
  sbs_pkg::sbs_dev_e dv;
  logic all_idle, illegal, live;
  logic [1:0] bbank;
  int error_cnt;
  int n_tests;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  sbs_ctl_model ctl (.i_core_clk(clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ap(ap), .o_bank(bsel));

  sbs_bank_tracker #(.PRE_CYC(PRE), .ACT_CYC(ACT), .REF_CYC(REF), .MODE_CYC(MODE),
    .XSR_CYC(XSR), .BURST_LEN(BL)) DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_cke(cke),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_auto_precharge_select(ap), .i_bank_select(bsel), .o_bank_state(bs),
    .o_dev_state(dv), .o_all_idle(all_idle), .o_cmd_illegal(illegal),
    .o_burst_bank(bbank), .o_burst_live(live));

  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [2:0] cur(input int sel);
    if (sel < 4) return bs[sel];
    return dv;
  endfunction

  // State st for n sampled cycles, then nxt
  task automatic run(input int sel, input logic [2:0] st, input int n, input logic [2:0] nxt);
    for (int i = 0; i < n; i++) begin
      chk(cur(sel), st);
      @(negedge clk);
    end
    chk(cur(sel), nxt);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++) chk(bs[i], sbs_pkg::BK_IDLE);
    chk(dv, sbs_pkg::DV_RUN);
    chk({2'b00, all_idle}, 3'h1);
    chk({2'b00, illegal}, 3'h0);
    chk({1'b0, bbank}, 3'h0);
    chk({2'b00, live}, 3'h0);
  endtask

  task automatic t_plain();
    ctl.issue(sbs_pkg::CM_ACT, 1'b0, 2'h0, 1'b1);
    run(0, sbs_pkg::BK_ACTIVATING, ACT, sbs_pkg::BK_ACTIVE);
    chk(bs[1], sbs_pkg::BK_IDLE);
    ctl.issue(sbs_pkg::CM_READ, 1'b0, 2'h0, 1'b1);
    chk({2'b00, live}, 3'h1);
    run(0, sbs_pkg::BK_READ, BL, sbs_pkg::BK_ACTIVE);
    chk({2'b00, live}, 3'h0);
    ctl.issue(sbs_pkg::CM_PRE, 1'b0, 2'h0, 1'b1);
    run(0, sbs_pkg::BK_PRECHARGING, PRE, sbs_pkg::BK_IDLE);
  endtask

  task automatic t_ap();
    sbs_pkg::sbs_cmd_e k;
    for (int i = 0; i < 2; i++) begin
      k = (i == 0) ? sbs_pkg::CM_READ : sbs_pkg::CM_WRITE;
      ctl.issue(sbs_pkg::CM_ACT, 1'b0, 2'h0, 1'b1);
      repeat (ACT) @(negedge clk);
      ctl.issue(k, 1'b1, 2'h0, 1'b1);
      chk({2'b00, live}, 3'h0);
      run(0, (i == 0) ? sbs_pkg::BK_READ_AP : sbs_pkg::BK_WRITE_AP, BL + PRE,
          sbs_pkg::BK_IDLE);
    end
  endtask

  task automatic t_term();
    ctl.issue(sbs_pkg::CM_ACT, 1'b0, 2'h0, 1'b1);
    ctl.issue(sbs_pkg::CM_ACT, 1'b0, 2'h3, 1'b1);
    repeat (ACT) @(negedge clk);
    ctl.issue(sbs_pkg::CM_READ, 1'b0, 2'h0, 1'b1);
    ctl.issue(sbs_pkg::CM_WRITE, 1'b0, 2'h3, 1'b1);
    chk(bs[0], sbs_pkg::BK_ACTIVE);
    chk(bs[3], sbs_pkg::BK_WRITE);
    chk({1'b0, bbank}, 3'h3);
    ctl.issue(sbs_pkg::CM_TERM, 1'b0, 2'h0, 1'b1);
    chk(bs[3], sbs_pkg::BK_ACTIVE);
    chk({2'b00, live}, 3'h0);
    ctl.issue(sbs_pkg::CM_ACT, 1'b0, 2'h3, 1'b1);
    chk({2'b00, illegal}, 3'h1);
    chk(bs[3], sbs_pkg::BK_ACTIVE);
    ctl.issue(sbs_pkg::CM_PRE, 1'b1, 2'h2, 1'b1);
    chk(bs[0], sbs_pkg::BK_PRECHARGING);
    run(4, sbs_pkg::DV_PRE_ALL, PRE, sbs_pkg::DV_RUN);
    chk(bs[3], sbs_pkg::BK_IDLE);
    chk({2'b00, all_idle}, 3'h1);
  endtask

  task automatic t_pre_idle();
    ctl.issue(sbs_pkg::CM_PRE, 1'b0, 2'h2, 1'b1);
    chk(bs[2], sbs_pkg::BK_IDLE);
    chk({2'b00, illegal}, 3'h0);
  endtask

  task automatic t_ref();
    ctl.issue(sbs_pkg::CM_REF, 1'b0, 2'h0, 1'b1);
    chk({2'b00, all_idle}, 3'h0);
    ctl.issue(sbs_pkg::CM_ACT, 1'b0, 2'h2, 1'b1);
    chk({2'b00, illegal}, 3'h1);
    chk(bs[2], sbs_pkg::BK_IDLE);
    run(4, sbs_pkg::DV_REFRESH, REF - 2, sbs_pkg::DV_RUN);
    chk({2'b00, all_idle}, 3'h1);
    ctl.issue(sbs_pkg::CM_MODE, 1'b0, 2'h0, 1'b1);
    run(4, sbs_pkg::DV_MODE, MODE, sbs_pkg::DV_RUN);
  endtask

  task automatic t_cke();
    ctl.issue(sbs_pkg::CM_NOP, 1'b0, 2'h0, 1'b0);
    ctl.issue(sbs_pkg::CM_ACT, 1'b0, 2'h0, 1'b1);
    chk(bs[0], sbs_pkg::BK_IDLE);
    ctl.issue(sbs_pkg::CM_REF, 1'b0, 2'h0, 1'b0);
    chk(dv, sbs_pkg::DV_SELF_REF);
    ctl.issue(sbs_pkg::CM_NOP, 1'b0, 2'h0, 1'b1);
    run(4, sbs_pkg::DV_SR_EXIT, XSR, sbs_pkg::DV_RUN);
  endtask

  task automatic test_done();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    error_cnt = 0;
    n_tests = 0;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_plain();
    t_ap();
    t_term();
    t_pre_idle();
    t_ref();
    t_cke();
    test_done();
  end

  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule

`default_nettype wire
